// *** core/tbqc_pkg.sv ***
package tbqc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 3;
	// register byte addresses
	localparam logic [31:0] CCR_BASE = 32'h4001_0000;
	localparam logic [31:0] CH_STRIDE = 32'h0000_0040;
	localparam logic [31:0] BCR_ADDR = 32'h4001_00C0;
	localparam logic [31:0] BMR_ADDR = 32'h4001_00C4;
	localparam logic [31:0] QIER_ADDR = 32'h4001_00C8;
	localparam logic [31:0] QIDR_ADDR = 32'h4001_00CC;
	localparam logic [31:0] QIMR_ADDR = 32'h4001_00D0;
	localparam logic [31:0] QISR_ADDR = 32'h4001_00D4;
	localparam logic [31:0] WPR_ADDR = 32'h4001_00E4;
	// write protect key sits in bits 31:8
	localparam logic [23:0] WP_KEY = 24'h54494D;
	localparam int WP_KEY_LSB = 8;
	localparam int WP_EN_BIT = 0;
	// command bits
	localparam int SYNC_BIT = 0;
	localparam int COUNTER_CLOCK_ENABLE_CMD_BIT = 0;
	localparam int COUNTER_CLOCK_DISABLE_CMD_BIT = 1;
	localparam int SOFTWARE_TRIGGER_CMD_BIT = 2;
	// block configuration fields
	localparam int XC0S_LSB = 0;
	localparam int XC1S_LSB = 2;
	localparam int XC2S_LSB = 4;
	localparam int DECODER_ENABLE_BIT = 8;
	localparam int POSITION_MEASURE_ENABLE_BIT = 9;
	localparam int SPEED_MEASURE_ENABLE_BIT = 10;
	localparam int TRANSPARENT_DECODING_BIT = 11;
	localparam int PHASE_A_ONLY_EDGES_BIT = 12;
	localparam int INVERT_PHASE_A_BIT = 13;
	localparam int INVERT_PHASE_B_BIT = 14;
	localparam int INVERT_INDEX_BIT = 15;
	localparam int SWAP_BIT = 16;
	localparam int IDXSEL_BIT = 17;
	localparam int FILTER_BIT = 19;
	localparam int MAXF_LSB = 20;
	localparam int MAXF_W = 6;
	localparam logic [31:0] BMR_WMASK = 32'h03FB_FF3F;
	localparam logic [31:0] BMR_RESET = 32'h0000_0000;
	// clock source selector codes
	localparam logic [1:0] XSEL_PIN = 2'h0;
	localparam logic [1:0] XSEL_LINE_X = 2'h2;
	localparam logic [1:0] XSEL_LINE_2 = 2'h3;
	// event bits in mask and status
	localparam int EV_IDX = 0;
	localparam int EV_DIRECTION_CHANGE_EVENT = 1;
	localparam int EV_QUADRATURE_ERROR_EVENT = 2;
	localparam int DIR_BIT = 8;
	localparam int GAP_W = 7;
	localparam logic [6:0] GAP_MAX = 7'h7F;
endpackage

// *** core/tbqc_core.sv ***
`timescale 1ns/1ps
module tbqc_core
	import tbqc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tbqc_pkg::ADDR_W-1:0] paddr,
	input wire logic [tbqc_pkg::DATA_W-1:0] pwdata,
	output logic [tbqc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [tbqc_pkg::NUM_CH-1:0] extClkPin,
	input wire logic chan0LineA,
	input wire logic chan0LineB,
	input wire logic chan1LineA,
	input wire logic chan2LineA,
	output logic [tbqc_pkg::NUM_CH-1:0] externalClock,
	output logic [tbqc_pkg::NUM_CH-1:0] chanTrigger,
	output logic [tbqc_pkg::NUM_CH-1:0] chanClockOn,
	output logic phaseA,
	output logic phaseB,
	output logic indexLevel,
	output logic countEdge,
	output logic direction,
	output logic posMeasureOn,
	output logic speedMeasureOn,
	output logic decoderIrq
);
	import tbqc_pkg::*;

	typedef struct packed {
		logic [31:0] bmr;
		logic write_protect_enable;
		logic [2:0] mask;
		logic [2:0] flags;
		logic [2:0] reported;
		logic [2:0][MAXF_W-1:0] fltCnt;
		logic [2:0] stab;
		logic [GAP_W-1:0] gap;
		logic dir;
		logic edgePulse;
		logic [2:0] chanClk;
		logic [2:0] chanTrig;
		logic [2:0] extClk;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic irq;
		logic position_measure_enable;
		logic speed_measure_enable;
	} tbqc_state_t;

	tbqc_state_t s_r;
	tbqc_state_t s_nxt;
	logic setupPh;
	logic accPh;
	logic [2:0] cond;
	logic [2:0] edgeF;
	logic [2:0] ev;
	logic [2:0] clr;
	logic [MAXF_W-1:0] maxf;
	logic qdOn;

	// pick a source selected by a two-bit code
	function automatic logic pickClk(input logic [1:0] sel, input logic pin,
		input logic lineX, input logic line2);
		logic r;
		r = 1'b0;
		case (sel)
			XSEL_PIN: r = pin;
			XSEL_LINE_X: r = lineX;
			XSEL_LINE_2: r = line2;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// true for every decoded address
	function automatic logic isMapped(input logic [31:0] a);
		logic m;
		m = (a == BCR_ADDR) || (a == BMR_ADDR) || (a == QIER_ADDR) || (a == QIDR_ADDR);
		m = m || (a == QIMR_ADDR) || (a == QISR_ADDR) || (a == WPR_ADDR);
		for (int c = 0; c < NUM_CH; c++)
		begin
			m = m || (a == CCR_BASE + 32'(c) * CH_STRIDE);
		end
		return m;
	endfunction

	// next-state logic of the whole block
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.chanTrig = '0;
		s_nxt.edgePulse = 1'b0;
		ev = '0;
		clr = '0;
		maxf = s_r.bmr[MAXF_LSB +: MAXF_W];
		qdOn = s_r.bmr[DECODER_ENABLE_BIT];
		setupPh = psel & ~penable;
		accPh = psel & penable & s_r.pready;

		// apb: one wait-free access phase, read data prepared in setup
		s_nxt.pready = setupPh;
		s_nxt.pslverr = 1'b0;
		if (setupPh)
		begin
			s_nxt.pslverr = ~isMapped(paddr);
			s_nxt.prdata = '0;
			s_nxt.reported = '0;
			case (paddr)
				BMR_ADDR: s_nxt.prdata = s_r.bmr;
				QIMR_ADDR: s_nxt.prdata = {29'h0, s_r.mask};
				QISR_ADDR:
				begin
					s_nxt.prdata = {23'h0, s_r.dir, 5'h0, s_r.flags};
					s_nxt.reported = s_r.flags;
				end
				WPR_ADDR: s_nxt.prdata = {31'h0, s_r.write_protect_enable};
				default: s_nxt.prdata = '0;
			endcase
		end

		// status read clears only the flags it reported
		if (accPh && !pwrite && paddr == QISR_ADDR)
			clr = s_r.reported;

		// register writes
		if (accPh && pwrite)
		begin
			case (paddr)
				BCR_ADDR:
					if (pwdata[SYNC_BIT])
						s_nxt.chanTrig = '1;
				BMR_ADDR:
					if (!s_r.write_protect_enable)
						s_nxt.bmr = pwdata & BMR_WMASK;
				QIER_ADDR: s_nxt.mask = s_r.mask | pwdata[2:0];
				QIDR_ADDR: s_nxt.mask = s_r.mask & ~pwdata[2:0];
				WPR_ADDR:
					if (pwdata[31:WP_KEY_LSB] == WP_KEY)
						s_nxt.write_protect_enable = pwdata[WP_EN_BIT];
				default:
				begin
				end
			endcase
			// per-channel commands, disable beats the clock start of enable and trigger, the trigger pulse still fires
			for (int c = 0; c < NUM_CH; c++)
			begin
				if (paddr == CCR_BASE + 32'(c) * CH_STRIDE)
				begin
					if (pwdata[SOFTWARE_TRIGGER_CMD_BIT])
					begin
						s_nxt.chanTrig[c] = 1'b1;
						s_nxt.chanClk[c] = 1'b1;
					end
					if (pwdata[COUNTER_CLOCK_ENABLE_CMD_BIT])
						s_nxt.chanClk[c] = 1'b1;
					if (pwdata[COUNTER_CLOCK_DISABLE_CMD_BIT])
						s_nxt.chanClk[c] = 1'b0;
				end
			end
		end
		// a sync trigger also starts every clock
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (s_nxt.chanTrig[c] && !(accPh && pwrite && pwdata[COUNTER_CLOCK_DISABLE_CMD_BIT]
				&& paddr == CCR_BASE + 32'(c) * CH_STRIDE))
				s_nxt.chanClk[c] = 1'b1;
		end

		// external clock routing
		s_nxt.extClk[0] = pickClk(s_r.bmr[XC0S_LSB +: 2], extClkPin[0],
			chan1LineA, chan2LineA);
		s_nxt.extClk[1] = pickClk(s_r.bmr[XC1S_LSB +: 2], extClkPin[1],
			chan0LineA, chan2LineA);
		s_nxt.extClk[2] = pickClk(s_r.bmr[XC2S_LSB +: 2], extClkPin[2],
			chan1LineA, chan2LineA);

		// input conditioning: invert, swap, index source
		cond[0] = chan0LineA ^ s_r.bmr[INVERT_PHASE_A_BIT];
		cond[1] = chan0LineB ^ s_r.bmr[INVERT_PHASE_B_BIT];
		if (s_r.bmr[SWAP_BIT])
			cond[1:0] = {cond[0], cond[1]};
		cond[2] = (s_r.bmr[IDXSEL_BIT] ? chan0LineB : chan1LineA)
			^ s_r.bmr[INVERT_INDEX_BIT];

		// glitch filters: a level must hold maxf+1 cycles to pass
		for (int i = 0; i < 3; i++)
		begin
			if (!qdOn || !s_r.bmr[FILTER_BIT])
			begin
				s_nxt.stab[i] = cond[i];
				s_nxt.fltCnt[i] = '0;
			end
			else if (cond[i] == s_r.stab[i])
				s_nxt.fltCnt[i] = '0;
			else if (s_r.fltCnt[i] >= maxf)
			begin
				s_nxt.stab[i] = cond[i];
				s_nxt.fltCnt[i] = '0;
			end
			else
				s_nxt.fltCnt[i] = s_r.fltCnt[i] + 1'b1;
		end
		edgeF = qdOn ? (s_nxt.stab ^ s_r.stab) : 3'b000;

		// quadrature error: phase edges closer than maxf+1 cycles
		if (!qdOn)
			s_nxt.gap = GAP_MAX;
		else if (edgeF[1:0] != 2'b00)
		begin
			if (s_r.gap < {1'b0, maxf})
				ev[EV_QUADRATURE_ERROR_EVENT] = 1'b1;
			s_nxt.gap = '0;
		end
		else if (s_r.gap != GAP_MAX)
			s_nxt.gap = s_r.gap + 1'b1;

		// counted edges and direction
		if (edgeF[0] || (edgeF[1] && !s_r.bmr[PHASE_A_ONLY_EDGES_BIT]))
		begin
			s_nxt.edgePulse = 1'b1;
			if (!s_r.bmr[TRANSPARENT_DECODING_BIT])
			begin
				s_nxt.dir = edgeF[0] ? (s_nxt.stab[0] ^ s_nxt.stab[1])
					: ~(s_nxt.stab[0] ^ s_nxt.stab[1]);
				ev[EV_DIRECTION_CHANGE_EVENT] = s_nxt.dir != s_r.dir;
			end
		end
		ev[EV_IDX] = edgeF[2] & s_nxt.stab[2];

		// sticky flags, a new event wins over the read clear
		s_nxt.flags = (s_r.flags & ~clr) | ev;
		s_nxt.irq = |(s_r.flags & s_r.mask);
		s_nxt.position_measure_enable = qdOn & s_r.bmr[POSITION_MEASURE_ENABLE_BIT];
		s_nxt.speed_measure_enable = qdOn & s_r.bmr[SPEED_MEASURE_ENABLE_BIT];
	end

	// state register with synchronous reset
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			s_r <= '0;
			s_r.bmr <= BMR_RESET;
			s_r.gap <= GAP_MAX;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign externalClock = s_r.extClk;
	assign chanTrigger = s_r.chanTrig;
	assign chanClockOn = s_r.chanClk;
	assign phaseA = s_r.stab[0];
	assign phaseB = s_r.stab[1];
	assign indexLevel = s_r.stab[2];
	assign countEdge = s_r.edgePulse;
	assign direction = s_r.dir;
	assign posMeasureOn = s_r.position_measure_enable;
	assign speedMeasureOn = s_r.speed_measure_enable;
	assign decoderIrq = s_r.irq;

	// checks
	AST_SYNC: assert property (@(posedge sys_clk) disable iff (!resetn)
		accPh && pwrite && paddr == BCR_ADDR && pwdata[SYNC_BIT]
		|=> chanTrigger == 3'b111 ##1 chanTrigger == 3'b000)
		else $error("sync write did not trigger all channels once");
	AST_WPROT: assert property (@(posedge sys_clk) disable iff (!resetn)
		accPh && pwrite && paddr == BMR_ADDR && s_r.write_protect_enable |=> $stable(s_r.bmr))
		else $error("protected block configuration changed");
	AST_XC0: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[1:0] == XSEL_LINE_X |=> externalClock[0] == $past(chan1LineA))
		else $error("ext clock 0 not routed from channel 1 line A");
	AST_XC1: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[3:2] == XSEL_LINE_X |=> externalClock[1] == $past(chan0LineA))
		else $error("ext clock 1 not routed from channel 0 line A");
	AST_XC2: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[5:4] == XSEL_LINE_2 |=> externalClock[2] == $past(chan2LineA))
		else $error("ext clock 2 not routed from channel 2 line A");
	AST_QDOFF: assert property (@(posedge sys_clk) disable iff (!resetn)
		!qdOn |=> !countEdge && !posMeasureOn && !speedMeasureOn)
		else $error("decoder active while disabled");
	AST_TRANS: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[TRANSPARENT_DECODING_BIT] |=> $stable(direction) && !s_r.flags[EV_DIRECTION_CHANGE_EVENT]
		|| $past(s_r.flags[EV_DIRECTION_CHANGE_EVENT]))
		else $error("direction decoded in transparent mode");
	AST_FILT: assert property (@(posedge sys_clk) disable iff (!resetn)
		qdOn && s_r.bmr[FILTER_BIT] && s_nxt.stab[0] != s_r.stab[0]
		|-> s_r.fltCnt[0] == maxf)
		else $error("filtered phase passed a short pulse");
	AST_COUNTER_CLOCK_DISABLE_CMD: assert property (@(posedge sys_clk) disable iff (!resetn)
		accPh && pwrite && paddr == CCR_BASE && pwdata[COUNTER_CLOCK_DISABLE_CMD_BIT]
		|=> !chanClockOn[0])
		else $error("clock disable command ignored");
	AST_SOFTWARE_TRIGGER_CMD: assert property (@(posedge sys_clk) disable iff (!resetn)
		accPh && pwrite && paddr == CCR_BASE && pwdata[SOFTWARE_TRIGGER_CMD_BIT] && !pwdata[COUNTER_CLOCK_DISABLE_CMD_BIT]
		|=> chanTrigger[0] && chanClockOn[0])
		else $error("software trigger did not start channel 0");
	AST_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
		accPh && pwrite && paddr == QIER_ADDR && pwdata[EV_QUADRATURE_ERROR_EVENT] |=> s_r.mask[EV_QUADRATURE_ERROR_EVENT])
		else $error("interrupt enable write did not set mask");
	AST_QUADRATURE_ERROR_EVENT: assert property (@(posedge sys_clk) disable iff (!resetn)
		edgeF[1:0] != 2'b00 && s_r.gap < {1'b0, maxf} |=> s_r.flags[EV_QUADRATURE_ERROR_EVENT])
		else $error("close phase edges not flagged");
	AST_IRQ: assert property (@(posedge sys_clk) disable iff (!resetn)
		|(s_r.flags & s_r.mask) |=> decoderIrq)
		else $error("interrupt request missing");
	AST_POS: assert property (@(posedge sys_clk) disable iff (!resetn)
		qdOn && s_r.bmr[POSITION_MEASURE_ENABLE_BIT] |=> posMeasureOn)
		else $error("position measurement not enabled");
	AST_SPEED: assert property (@(posedge sys_clk) disable iff (!resetn)
		qdOn && s_r.bmr[SPEED_MEASURE_ENABLE_BIT] |=> speedMeasureOn)
		else $error("speed measurement not enabled");
	AST_PHASE_A_ONLY_EDGES: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[PHASE_A_ONLY_EDGES_BIT] && !edgeF[0] |=> !countEdge)
		else $error("phase B edge counted in phase A only mode");
	AST_XC0PIN: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[1:0] == XSEL_PIN |=> externalClock[0] == $past(extClkPin[0]))
		else $error("ext clock 0 not routed from its pin");
	AST_IDXEV: assert property (@(posedge sys_clk) disable iff (!resetn)
		edgeF[2] && s_nxt.stab[2] |=> s_r.flags[EV_IDX])
		else $error("index rise not flagged");
	AST_RDCLR: assert property (@(posedge sys_clk) disable iff (!resetn)
		accPh && !pwrite && paddr == QISR_ADDR && ev == 3'b000
		|=> (s_r.flags & $past(s_r.reported)) == 3'b000)
		else $error("reported status flag survived its read");
	AST_DIRBIT: assert property (@(posedge sys_clk) disable iff (!resetn)
		setupPh && paddr == QISR_ADDR |=> prdata[DIR_BIT] == $past(direction))
		else $error("status direction bit wrong");
	AST_MASKRD: assert property (@(posedge sys_clk) disable iff (!resetn)
		setupPh && paddr == QIMR_ADDR |=> prdata[2:0] == $past(s_r.mask))
		else $error("mask read data wrong");
	AST_INV: assert property (@(posedge sys_clk) disable iff (!resetn)
		!s_r.bmr[SWAP_BIT] && !(qdOn && s_r.bmr[FILTER_BIT])
		|=> phaseA == ($past(chan0LineA) ^ $past(s_r.bmr[INVERT_PHASE_A_BIT])))
		else $error("phase A polarity wrong");
	AST_SWAP: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[SWAP_BIT] && !(qdOn && s_r.bmr[FILTER_BIT])
		|=> phaseA == ($past(chan0LineB) ^ $past(s_r.bmr[INVERT_PHASE_B_BIT])))
		else $error("phases not swapped");
	AST_IDXSRC: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_r.bmr[IDXSEL_BIT] && !(qdOn && s_r.bmr[FILTER_BIT])
		|=> indexLevel == ($past(chan0LineB) ^ $past(s_r.bmr[INVERT_INDEX_BIT])))
		else $error("index not taken from channel 0 line B");
endmodule

// *** sim/tbqc_enc_model.sv ***
`timescale 1ns/1ps
// rotary encoder stand-in: gray phases and an index once every eight steps
module tbqc_enc_model
(
	input wire logic sys_clk,
	input wire logic stepReq,
	input wire logic stepDir,
	output logic lineA,
	output logic lineB,
	output logic idx
);
	int pos = 0;

	// one quarter step per request, upward while stepDir is high
	always @(posedge sys_clk)
		if (stepReq)
			pos <= stepDir ? pos + 1 : pos - 1;

	// phase A leads phase B when counting upward
	assign lineA = pos[1] ^ pos[0];
	assign lineB = pos[1];
	assign idx = (pos[2:0] == 3'h0);
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, s) begin numChecks++; if ((s) !== (e)) begin nMismatch++; \
	$display("wrong value %s exp %0h seen %0h", nm, e, s); end end
module tb;
	import tbqc_pkg::*;
	logic sys_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata, seed = 32'h2B96BE27;
	logic pready, pslverr, rerr, useEnc = 1'h0, stepReq = 1'h0, stepDir = 1'h0, glitch = 1'h0;
	logic [2:0] extClkPin = 3'h0, externalClock, chanTrigger, chanClockOn;
	logic [3:0] rndLine = 4'h0;
	logic encA, encB, encIdx, phaseA, phaseB, indexLevel, countEdge, direction, idxPrev;
	logic posMeasureOn, speedMeasureOn, decoderIrq, chan0LineA, chan0LineB, chan1LineA, chan2LineA;
	int nMismatch = 0, numChecks = 0, edges = 0, idxToggles = 0;
	int cfgBit[6] = '{31, SWAP_BIT, INVERT_PHASE_A_BIT, INVERT_PHASE_B_BIT, IDXSEL_BIT, INVERT_INDEX_BIT};
	logic [5:0] dirExp = 6'b110001;
	logic [2:0] trigLog[$];

	always #12.5 sys_clk = ~sys_clk;

	tbqc_core tbqc_core_i(.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .extClkPin, .chan0LineA, .chan0LineB, .chan1LineA,
		.chan2LineA, .externalClock, .chanTrigger, .chanClockOn, .phaseA, .phaseB,
		.indexLevel, .countEdge, .direction, .posMeasureOn, .speedMeasureOn, .decoderIrq);
	tbqc_enc_model tbqc_enc_model_i(.sys_clk, .stepReq, .stepDir, .lineA(encA),
		.lineB(encB), .idx(encIdx));

	// channel lines come from the encoder or from random levels
	assign chan0LineA = useEnc ? encA : rndLine[0];
	assign chan0LineB = useEnc ? encB : rndLine[1];
	assign chan1LineA = useEnc ? encIdx ^ glitch : rndLine[2];
	assign chan2LineA = rndLine[3];

	// event monitors on design outputs
	always @(posedge sys_clk)
	begin
		if (countEdge === 1'h1) edges++;
		if (chanTrigger !== 3'h0) trigLog.push_back(chanTrigger);
		if (indexLevel !== idxPrev) idxToggles++;
		idxPrev <= indexLevel;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic expRoute(input int i, input logic [1:0] s);
		case (s)
			2'h0: return extClkPin[i];
			2'h2: return (i == 1) ? chan0LineA : chan1LineA;
			2'h3: return chan2LineA;
			default: return 1'h0;
		endcase
	endfunction

	// one bus transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		repeat (3) @(posedge sys_clk);
	endtask

	// encoder steps; gap 0 gives one edge per cycle
	task automatic steps(input int n, input logic d, input int gap);
		stepDir <= d;
		repeat (n)
		begin
			stepReq <= 1'h1;
			@(posedge sys_clk);
			if (gap > 0) stepReq <= 1'h0;
			repeat (gap) @(posedge sys_clk);
		end
		stepReq <= 1'h0;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		logic [31:0] v, msk, ca;
		int exp;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'h1;
		@(posedge sys_clk);
		apb(1'h0, BMR_ADDR, 32'h0);
		`CHK("config reset", BMR_RESET, rdata)
		apb(1'h0, 32'h4001_00F0, 32'h0);
		`CHK("unmapped", 1'h1, rerr)
		for (int i = 0; i < 3; i++)
			for (int s = 0; s < 4; s++)
			begin
				apb(1'h1, BMR_ADDR, 32'(s) << (2 * i));
				repeat (2)
				begin
					seed = lfsr(seed);
					extClkPin <= seed[2:0];
					rndLine <= seed[6:3];
					repeat (3) @(posedge sys_clk);
					`CHK("ext clock", expRoute(i, 2'(s)), externalClock[i])
				end
			end
		$display("test routing done");
		trigLog.delete();
		apb(1'h1, BCR_ADDR, 32'h0);
		apb(1'h1, BCR_ADDR, 32'h1 << SYNC_BIT);
		`CHK("sync count", 1, trigLog.size())
		`CHK("sync lines", 3'h7, trigLog[0])
		for (int c = 0; c < 3; c++)
		begin
			ca = CCR_BASE + CH_STRIDE * c;
			apb(1'h1, ca, 32'h2);
			`CHK("clock off", 1'h0, chanClockOn[c])
			apb(1'h1, ca, 32'h1);
			`CHK("clock on", 1'h1, chanClockOn[c])
			apb(1'h1, ca, 32'h3);
			`CHK("both commands", 1'h0, chanClockOn[c])
			trigLog.delete();
			apb(1'h1, ca, 32'h4);
			`CHK("trigger clock", 1'h1, chanClockOn[c])
			`CHK("trigger line", 3'h1 << c, trigLog[0])
		end
		$display("test commands done");
		msk = 32'h0;
		for (int k = 0; k < 6; k++)
		begin
			seed = lfsr(seed);
			apb(1'h1, k[0] ? QIDR_ADDR : QIER_ADDR, {29'h0, seed[2:0]});
			msk = k[0] ? (msk & ~{29'h0, seed[2:0]}) : (msk | {29'h0, seed[2:0]});
			apb(1'h0, QIMR_ADDR, 32'h0);
			`CHK("mask", msk, rdata)
		end
		apb(1'h1, QIER_ADDR, 32'h7);
		apb(1'h1, BMR_ADDR, 32'h15);
		apb(1'h1, WPR_ADDR, {WP_KEY, 8'h01});
		apb(1'h1, BMR_ADDR, 32'h3F);
		apb(1'h0, BMR_ADDR, 32'h0);
		`CHK("protected config", 32'h15, rdata)
		apb(1'h1, WPR_ADDR, {WP_KEY, 8'h00});
		seed = lfsr(seed);
		apb(1'h1, BMR_ADDR, seed);
		apb(1'h0, BMR_ADDR, 32'h0);
		`CHK("config readback", seed & BMR_WMASK, rdata)
		`CHK("position on", seed[DECODER_ENABLE_BIT] & seed[POSITION_MEASURE_ENABLE_BIT], posMeasureOn)
		`CHK("speed on", seed[DECODER_ENABLE_BIT] & seed[SPEED_MEASURE_ENABLE_BIT], speedMeasureOn)
		$display("test registers done");
		apb(1'h1, BMR_ADDR, 32'h0);
		useEnc <= 1'h1;
		exp = edges;
		steps(4, 1'h1, 3);
		`CHK("edges while off", exp, edges)
		v = 32'h0020_0300; // decoder with position measure, filter width 2
		for (int k = 0; k < 6; k++)
		begin
			apb(1'h1, BMR_ADDR, v | (32'h1 << cfgBit[k]));
			exp = edges;
			steps(4, 1'h1, 3);
			`CHK("direction", dirExp[k], direction)
			`CHK("edges", exp + 4, edges)
			`CHK("index", (k == 4 ? encB : encIdx) ^ (k == 5), indexLevel)
			`CHK("phase A", (k == 1) ? encB : (encA ^ (k == 2)), phaseA)
			`CHK("phase B", (k == 1) ? encA : (encB ^ (k == 3)), phaseB)
		end
		apb(1'h1, BMR_ADDR, v | (32'h1 << PHASE_A_ONLY_EDGES_BIT));
		exp = edges;
		steps(4, 1'h1, 3);
		`CHK("phase A edges", exp + 2, edges)
		apb(1'h1, BMR_ADDR, v);
		apb(1'h0, QISR_ADDR, 32'h0);
		steps(8, 1'h1, 3);
		apb(1'h0, QISR_ADDR, 32'h0);
		`CHK("status forward", 32'h101, rdata & 32'h105)
		steps(2, 1'h0, 3);
		`CHK("irq", 1'h1, decoderIrq)
		apb(1'h0, QISR_ADDR, 32'h0);
		`CHK("status reverse", 32'h2, rdata & 32'h106)
		apb(1'h0, QISR_ADDR, 32'h0);
		`CHK("status cleared", 32'h0, rdata & 32'h7)
		`CHK("irq cleared", 1'h0, decoderIrq)
		steps(4, 1'h1, 0);
		apb(1'h0, QISR_ADDR, 32'h0);
		`CHK("quad error", 32'h4, rdata & 32'h4)
		apb(1'h1, BMR_ADDR, v | (32'h1 << TRANSPARENT_DECODING_BIT));
		exp = edges;
		steps(2, 1'h0, 3);
		apb(1'h0, QISR_ADDR, 32'h0);
		`CHK("transparent edges", exp + 2, edges)
		`CHK("transparent no change", 32'h0, rdata & 32'h2)
		$display("test decoder done");
		apb(1'h1, BMR_ADDR, v | (32'h1 << FILTER_BIT));
		for (int w = 2; w < 4; w++)
		begin
			exp = idxToggles;
			glitch <= 1'h1;
			repeat (w) @(posedge sys_clk);
			glitch <= 1'h0;
			repeat (8) @(posedge sys_clk);
			`CHK("index pulse", exp + (w - 2) * 2, idxToggles)
		end
		$display("test filter done");
		printVerdict();
	end

	// watchdog, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		nMismatch++;
		printVerdict();
	end
endmodule
